// [clkc_output_ctrl.sv]
`timescale 1ns/10ps
// ==========================================================
// How it works
// (R1) each differential pair has its own enable
// (R2) single-ended enables in byte one, bits 7-3
// (R3) spread on/off and spread depth bits
// (R4) 48 and 33 MHz drive strength select
// (R5) request-stopped main pairs driven or tri-state
// (R6) processor pairs power-down drive mode
// (R7) main pairs power-down drive mode
// (R8) link clock drive strength select
// (R9) link clock output enable
// (R10) request pin 0 stop map for main pairs
// (R11) request pin 1 stop map for main pairs
// (R12) test-clock mode entry bit
// (R13) test mode: divided reference or tri-state
// (R14) reference outputs drive strength select
// (R15) command byte: mode, chip select, index
// (R16) request accepted after two main pair rises
// (R17) stop after next transition, true high
// (R18) stopped pairs resume together, glitch free
// (R19) reserved bits stored and read back
// (R20) enable changes only at cycle boundary
module clkc_output_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] clockRequestN,
    input wire logic powerDownN,
    output logic [9:0] diffPairT,
    output logic [9:0] diffPairC,
    output logic [9:0] diffPairOe,
    output logic [5:0] seClk,
    output logic [5:0] seOe,
    output logic spreadOn,
    output logic spreadDeep,
    output logic usb48DriveSingle,
    output logic bus33DriveSingle,
    output logic link66LowDrive,
    output logic refHighDrive
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_RX,
        S_RX_ACK,
        S_TX,
        S_TX_ACK
    } clkc_ser_t;

    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclS3;
        logic sdaS1;
        logic sdaS2;
        logic sdaS3;
        logic pdS1;
        logic pdS2;
        clkc_ser_t st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [4:0] ptr;
        logic rd;
        logic blk;
        logic cmdSeen;
        logic cntPend;
        logic csOk;
        logic sdaOe;
        logic [6:0][7:0] regs;
        logic [7:0] mainCnt;
        logic [7:0] cpuCnt;
        logic mainPh;
        logic cpuPh;
        logic [5:0][7:0] seCnt;
        logic [5:0] sePh;
        logic [5:0] seEn;
        logic [5:0] seOut;
        logic [5:0] seOe;
        logic tcPrev;
    } clkc_top_t;

    clkc_top_t s_q;
    clkc_top_t s_d;

    // ====
    // helpers
    localparam logic [5:0][7:0] SE_HALF = {
        clkc_pkg::LINK66_HALF, clkc_pkg::USB48_HALF,
        clkc_pkg::BUS33_HALF, clkc_pkg::REF_HALF,
        clkc_pkg::REF_HALF, clkc_pkg::REF_HALF
    };

    function automatic logic [7:0] readByte(
        input logic [6:0][7:0] regs,
        input logic [4:0] idx
    );
        logic [7:0] v;
        v = 8'h00;
        if (idx < clkc_pkg::REG_NUM)
        begin
            v = regs[idx[2:0]]; // R19
        end
        else if (idx == clkc_pkg::IDX_VENDOR)
        begin
            v = clkc_pkg::VENDOR_BYTE;
        end
        return v;
    endfunction : readByte

    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic mainTick;
    logic cpuTick;
    logic mainRise;
    logic pd;
    logic req0Stop;
    logic req1Stop;
    logic mainTri;
    logic testMode;
    logic testSel;
    logic [5:0] mainStop;
    logic [5:0] seWant;
    logic [9:0] pairEn;
    logic [9:0] pairStop;
    logic [9:0] pairTri;
    logic [9:0] pairTick;
    logic [9:0] pairPh;

    // ====
    // pin edges, only the second and third stages are read
    assign sclRise = s_q.sclS2 && !s_q.sclS3;
    assign sclFall = !s_q.sclS2 && s_q.sclS3;
    assign startSeen = s_q.sclS2 && s_q.sclS3 && !s_q.sdaS2 && s_q.sdaS3;
    assign stopSeen = s_q.sclS2 && s_q.sclS3 && s_q.sdaS2 && !s_q.sdaS3;

    // ====
    // clock phase dividers
    assign mainTick = (s_q.mainCnt == clkc_pkg::MAIN_HALF - 8'h01);
    assign cpuTick = (s_q.cpuCnt == clkc_pkg::CPU_HALF - 8'h01);
    assign mainRise = mainTick && !s_q.mainPh;
    assign pd = !s_q.pdS2;
    assign testMode = s_q.regs[clkc_pkg::IDX_TEST][clkc_pkg::TEST_MODE]; // R12
    assign testSel = s_q.regs[clkc_pkg::IDX_TEST][clkc_pkg::TEST_SEL]; // R13

    // ====
    // per-pair steering
    always_comb
    begin
        mainStop = (s_q.regs[clkc_pkg::IDX_MAP0][7:clkc_pkg::MAP_LSB] & {6{req0Stop}}) // R10
            | (s_q.regs[clkc_pkg::IDX_MAP1][7:clkc_pkg::MAP_LSB] & {6{req1Stop}}) // R11
            | {6{pd}};
        // power-down mode wins over request mode when both stop a pair
        mainTri = pd ? s_q.regs[clkc_pkg::IDX_MODE][clkc_pkg::MODE_MAIN_PD_TRI] // R7
            : s_q.regs[clkc_pkg::IDX_MODE][clkc_pkg::MODE_REQ_TRI]; // R5
        pairEn = {s_q.regs[clkc_pkg::IDX_SE_EN][clkc_pkg::CPU_EN_LSB +: 2],
            s_q.regs[clkc_pkg::IDX_DIFF_EN][clkc_pkg::SEC_EN_LSB +: 2],
            s_q.regs[clkc_pkg::IDX_DIFF_EN][clkc_pkg::MAIN_EN_LSB +: 6]}; // R1
        pairStop = {{4{pd}}, mainStop};
        pairTri = {{2{s_q.regs[clkc_pkg::IDX_MODE][clkc_pkg::MODE_CPU_PD_TRI]}}, // R6
            {2{s_q.regs[clkc_pkg::IDX_MODE][clkc_pkg::MODE_MAIN_PD_TRI]}},
            {6{mainTri}}};
        pairTick = {{2{cpuTick}}, {8{mainTick}}};
        pairPh = {{2{~s_q.cpuPh}}, {8{~s_q.mainPh}}};
        seWant = {s_q.regs[clkc_pkg::IDX_MAP0][clkc_pkg::MAP0_LINK_EN], // R9
            s_q.regs[clkc_pkg::IDX_SE_EN][clkc_pkg::SE_USB48],
            s_q.regs[clkc_pkg::IDX_SE_EN][clkc_pkg::SE_BUS33],
            s_q.regs[clkc_pkg::IDX_SE_EN][clkc_pkg::SE_REF_LSB +: 3]}; // R2
    end

    // ====
    // next state
    always_comb
    begin
        logic [7:0] nb;
        nb = 8'h00;
        s_d = s_q;
        s_d.sclS1 = sclIn;
        s_d.sclS2 = s_q.sclS1;
        s_d.sclS3 = s_q.sclS2;
        s_d.sdaS1 = sdaIn;
        s_d.sdaS2 = s_q.sdaS1;
        s_d.sdaS3 = s_q.sdaS2;
        s_d.pdS1 = powerDownN;
        s_d.pdS2 = s_q.pdS1;

        // serial slave
        if (startSeen)
        begin
            s_d.st = S_ADDR;
            s_d.bitCnt = 4'h0;
            s_d.sdaOe = 1'b0;
        end
        else if (stopSeen)
        begin
            s_d.st = S_IDLE;
            s_d.sdaOe = 1'b0;
            s_d.cmdSeen = 1'b0;
        end
        else
        begin
            unique case (s_q.st)
                S_IDLE:
                begin
                    s_d.sdaOe = 1'b0;
                end
                S_ADDR:
                begin
                    if (sclRise)
                    begin
                        s_d.shift = {s_q.shift[6:0], s_q.sdaS2};
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end
                    else if (sclFall && s_q.bitCnt == clkc_pkg::BITS_PER_BYTE)
                    begin
                        if (s_q.shift[7:1] == clkc_pkg::SLAVE_ADDR)
                        begin
                            s_d.sdaOe = 1'b1;
                            s_d.rd = s_q.shift[0];
                            s_d.st = S_ADDR_ACK;
                        end
                        else
                        begin
                            s_d.st = S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK, S_TX_ACK:
                begin
                    if (s_q.st == S_TX_ACK && sclRise && s_q.sdaS2)
                    begin
                        // master refused more data
                        s_d.st = S_IDLE;
                    end
                    else if (sclFall)
                    begin
                        s_d.bitCnt = 4'h0;
                        if (s_q.rd)
                        begin
                            // block read opens with the byte count
                            if (s_q.cntPend)
                            begin
                                nb = clkc_pkg::BLOCK_LEN;
                                s_d.cntPend = 1'b0;
                            end
                            else
                            begin
                                nb = s_q.csOk ? readByte(s_q.regs, s_q.ptr) : 8'h00;
                                s_d.ptr = s_q.ptr + 5'h01;
                            end
                            s_d.shift = nb;
                            s_d.sdaOe = ~nb[7];
                            s_d.st = S_TX;
                        end
                        else
                        begin
                            s_d.sdaOe = 1'b0;
                            s_d.st = S_RX;
                        end
                    end
                end
                S_RX:
                begin
                    if (sclRise)
                    begin
                        s_d.shift = {s_q.shift[6:0], s_q.sdaS2};
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end
                    else if (sclFall && s_q.bitCnt == clkc_pkg::BITS_PER_BYTE)
                    begin
                        s_d.sdaOe = 1'b1;
                        s_d.st = S_RX_ACK;
                        if (!s_q.cmdSeen)
                        begin
                            s_d.cmdSeen = 1'b1;
                            s_d.blk = !s_q.shift[clkc_pkg::CMD_BYTE_MODE]; // R15
                            s_d.cntPend = !s_q.shift[clkc_pkg::CMD_BYTE_MODE];
                            s_d.csOk = (s_q.shift[6:5] == 2'b00); // R15
                            s_d.ptr = s_q.shift[clkc_pkg::CMD_BYTE_MODE]
                                ? s_q.shift[4:0] : 5'h00; // R15
                        end
                        else if (s_q.cntPend)
                        begin
                            s_d.cntPend = 1'b0;
                        end
                        else
                        begin
                            // whole byte stored, reserved bits too
                            if (s_q.csOk && s_q.ptr < clkc_pkg::REG_NUM)
                            begin
                                s_d.regs[s_q.ptr[2:0]] = s_q.shift; // R19
                            end
                            s_d.ptr = s_q.ptr + 5'h01;
                        end
                    end
                end
                S_RX_ACK:
                begin
                    if (sclFall)
                    begin
                        s_d.sdaOe = 1'b0;
                        s_d.bitCnt = 4'h0;
                        s_d.st = S_RX;
                    end
                end
                S_TX:
                begin
                    if (sclFall)
                    begin
                        if (s_q.bitCnt == 4'h7)
                        begin
                            s_d.sdaOe = 1'b0;
                            s_d.st = S_TX_ACK;
                        end
                        else
                        begin
                            s_d.shift = {s_q.shift[6:0], 1'b0};
                            s_d.sdaOe = ~s_q.shift[6];
                            s_d.bitCnt = s_q.bitCnt + 4'h1;
                        end
                    end
                end
            endcase
        end

        // differential phase generators
        s_d.mainCnt = mainTick ? 8'h00 : s_q.mainCnt + 8'h01;
        s_d.mainPh = mainTick ? ~s_q.mainPh : s_q.mainPh;
        s_d.cpuCnt = cpuTick ? 8'h00 : s_q.cpuCnt + 8'h01;
        s_d.cpuPh = cpuTick ? ~s_q.cpuPh : s_q.cpuPh;

        // single-ended outputs; enable sampled while high, taken at the falling edge
        for (int i = 0; i < 6; i++)
        begin
            if (s_q.seCnt[i] == SE_HALF[i] - 8'h01)
            begin
                s_d.seCnt[i] = 8'h00;
                s_d.sePh[i] = ~s_q.sePh[i];
                if (s_q.sePh[i])
                begin
                    s_d.seEn[i] = seWant[i]; // R2 R9 R20
                end
            end
            else
            begin
                s_d.seCnt[i] = s_q.seCnt[i] + 8'h01;
            end
            // a disabled output rests low; switch only at an edge of the followed clock
            if (testMode ? (s_q.sePh[0] != s_q.tcPrev) : (s_d.sePh[i] != s_q.sePh[i]))
            begin
                s_d.seOut[i] = testMode ? s_q.sePh[0] : (s_d.sePh[i] && s_d.seEn[i]); // R13
            end
            s_d.seOe[i] = testMode ? testSel : 1'b1; // R13
        end
        s_d.tcPrev = s_q.sePh[0];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.sclS1 <= 1'b1;
            s_q.sclS2 <= 1'b1;
            s_q.sclS3 <= 1'b1;
            s_q.sdaS1 <= 1'b1;
            s_q.sdaS2 <= 1'b1;
            s_q.sdaS3 <= 1'b1;
            s_q.pdS1 <= 1'b1;
            s_q.pdS2 <= 1'b1;
            s_q.st <= S_IDLE;
            s_q.regs <= {clkc_pkg::RST_TEST, clkc_pkg::RST_MAP1, clkc_pkg::RST_MAP0,
                clkc_pkg::RST_MODE, clkc_pkg::RST_SPREAD, clkc_pkg::RST_SE_EN,
                clkc_pkg::RST_DIFF_EN};
            s_q.seEn <= '1;
            s_q.seOe <= '1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ====
    // request pins and pairs
    clkc_req_filter u_req0 (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinN(clockRequestN[0]),
        .edgeTick(mainRise),
        .stopReq(req0Stop)
    );

    clkc_req_filter u_req1 (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinN(clockRequestN[1]),
        .edgeTick(mainRise),
        .stopReq(req1Stop)
    );

    for (genvar g = 0; g < 10; g++)
    begin : g_pair
        clkc_diff_pair u_pair (
            .mclk(mclk),
            .rst_n(rst_n),
            .tick(pairTick[g]),
            .phaseNext(pairPh[g]),
            .enable(pairEn[g]),
            .stop(pairStop[g]),
            .triMode(pairTri[g]),
            .testMode(testMode),
            .testSel(testSel),
            .testClk(s_q.sePh[0]),
            .pairT(diffPairT[g]),
            .pairC(diffPairC[g]),
            .pairOe(diffPairOe[g])
        );
    end

    // ====
    // outputs; data line is open drain
    assign sdaOut = 1'b0;
    assign sdaOe = s_q.sdaOe;
    assign seClk = s_q.seOut;
    assign seOe = s_q.seOe;
    assign spreadOn = s_q.regs[clkc_pkg::IDX_SPREAD][clkc_pkg::SPR_ON]; // R3
    assign spreadDeep = s_q.regs[clkc_pkg::IDX_SPREAD][clkc_pkg::SPR_DEPTH]; // R3
    assign usb48DriveSingle = s_q.regs[clkc_pkg::IDX_SPREAD][clkc_pkg::SPR_USB_DRV]; // R4
    assign bus33DriveSingle = s_q.regs[clkc_pkg::IDX_SPREAD][clkc_pkg::SPR_BUS_DRV]; // R4
    assign link66LowDrive = s_q.regs[clkc_pkg::IDX_MODE][clkc_pkg::MODE_LINK_DRV]; // R8
    assign refHighDrive = s_q.regs[clkc_pkg::IDX_TEST][clkc_pkg::TEST_REF_DRV]; // R14
endmodule : clkc_output_ctrl

// [clkc_pkg.sv]
// ==========================================================
// register map, reset values and timing
package clkc_pkg;
    // ====
    // register indices
    localparam logic [4:0] IDX_DIFF_EN = 5'h00;
    localparam logic [4:0] IDX_SE_EN = 5'h01;
    localparam logic [4:0] IDX_SPREAD = 5'h02;
    localparam logic [4:0] IDX_MODE = 5'h03;
    localparam logic [4:0] IDX_MAP0 = 5'h04;
    localparam logic [4:0] IDX_MAP1 = 5'h05;
    localparam logic [4:0] IDX_TEST = 5'h06;
    localparam logic [4:0] IDX_VENDOR = 5'h07;
    localparam logic [4:0] REG_NUM = 5'h07;

    // ====
    // power-up values
    localparam logic [7:0] RST_DIFF_EN = 8'hFF;
    localparam logic [7:0] RST_SE_EN = 8'hFF;
    localparam logic [7:0] RST_SPREAD = 8'hEB;
    localparam logic [7:0] RST_MODE = 8'hAF;
    localparam logic [7:0] RST_MAP0 = 8'h03;
    localparam logic [7:0] RST_MAP1 = 8'h00;
    // low nibble is hardware-set; zero here
    localparam logic [7:0] RST_TEST = 8'h10;
    // arbitrary value, names no real maker
    localparam logic [7:0] VENDOR_BYTE = 8'h5A;

    // ====
    // field positions
    localparam int MAIN_EN_LSB = 2;
    localparam int SEC_EN_LSB = 0;
    localparam int CPU_EN_LSB = 0;
    localparam int SE_REF_LSB = 5;
    localparam int SE_BUS33 = 4;
    localparam int SE_USB48 = 3;
    localparam int SPR_DEPTH = 7;
    localparam int SPR_USB_DRV = 6;
    localparam int SPR_BUS_DRV = 5;
    localparam int SPR_ON = 2;
    localparam int MODE_REQ_TRI = 7;
    localparam int MODE_CPU_PD_TRI = 6;
    localparam int MODE_MAIN_PD_TRI = 5;
    localparam int MODE_LINK_DRV = 0;
    localparam int MAP0_LINK_EN = 1;
    localparam int MAP_LSB = 2;
    localparam int TEST_SEL = 7;
    localparam int TEST_MODE = 6;
    localparam int TEST_REF_DRV = 5;

    // ====
    // serial command
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam int CMD_BYTE_MODE = 7;
    localparam logic [7:0] BLOCK_LEN = 8'h08;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ====
    // half periods in mclk cycles
    localparam logic [7:0] MAIN_HALF = 8'h02;
    localparam logic [7:0] CPU_HALF = 8'h01;
    localparam logic [7:0] REF_HALF = 8'h11;
    localparam logic [7:0] BUS33_HALF = 8'h08;
    localparam logic [7:0] USB48_HALF = 8'h05;
    localparam logic [7:0] LINK66_HALF = 8'h04;
endpackage : clkc_pkg

// [clkc_req_filter.sv]
`timescale 1ns/10ps
// ==========================================================
// request pin synchroniser and two-edge debounce
module clkc_req_filter (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pinN,
    input wire logic edgeTick,
    output logic stopReq
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic cand;
        logic level;
    } clkc_flt_t;

    clkc_flt_t s_q;
    clkc_flt_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.s1 = pinN;
        s_d.s2 = s_q.s1;
        if (edgeTick)
        begin
            // same level at two successive main pair rises
            s_d.cand = s_q.s2; // R16
            if (s_q.s2 == s_q.cand)
            begin
                s_d.level = s_q.s2; // R16
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign stopReq = s_q.level;
endmodule : clkc_req_filter

// [clkc_diff_pair.sv]
`timescale 1ns/10ps
// ==========================================================
// one differential output pair
module clkc_diff_pair (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic phaseNext,
    input wire logic enable,
    input wire logic stop,
    input wire logic triMode,
    input wire logic testMode,
    input wire logic testSel,
    input wire logic testClk,
    output logic pairT,
    output logic pairC,
    output logic pairOe
);
    typedef struct packed {
        logic run;
        logic t;
        logic c;
        logic oe;
        logic tc;
    } clkc_pair_t;

    clkc_pair_t s_q;
    clkc_pair_t s_d;

    always_comb
    begin
        s_d = s_q;
        // decisions only on the rising edge: no short pulse
        if (tick && phaseNext)
        begin
            s_d.run = enable && !stop; // R17 R20
            s_d.oe = s_d.run || (enable && !triMode); // R1 R5 R6 R7 R17
        end
        if (tick)
        begin
            // stopped pair rests true high, complement low
            s_d.t = s_d.run ? phaseNext : 1'b1; // R17 R18
            s_d.c = ~s_d.t;
        end
        s_d.tc = testClk;
        if (testMode)
        begin
            // follow the test clock only at its edges: no short pulse on entry
            s_d.t = (testClk != s_q.tc) ? testClk : s_q.t; // R13
            s_d.c = ~s_d.t;
            s_d.oe = testSel; // R13
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.run <= 1'b1;
            s_q.c <= 1'b1;
            s_q.oe <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pairT = s_q.t;
    assign pairC = s_q.c;
    assign pairOe = s_q.oe;
endmodule : clkc_diff_pair

// [clkc_props.sv]
`timescale 1ns/10ps
// ====
// port checks
module clkc_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic powerDownN,
    input wire logic sdaOe,
    input wire logic [9:0] diffPairT,
    input wire logic [9:0] diffPairC,
    input wire logic [9:0] diffPairOe,
    input wire logic [5:0] seClk,
    input wire logic [5:0] seOe,
    input wire logic spreadOn,
    input wire logic refHighDrive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_pdLong; !powerDownN [*8]; endsequence
    sequence s_busHigh; seClk[3] [*8]; endsequence
    AST_MAIN_PULSE: assert property ($rose(diffPairT[0]) |-> diffPairT[0] [*2])
        else $error("main pulse short");
    AST_BUS_PULSE: assert property ($rose(seClk[3]) |-> s_busHigh)
        else $error("33 MHz pulse short");
    AST_SPREAD_WR: assert property ($changed(spreadOn) |-> ##[0:3] sdaOe)
        else $error("spread moved");
    AST_REF_WR: assert property ($changed(refHighDrive) |=> ##[0:2] sdaOe)
        else $error("ref drive moved");
    AST_PD_STOP: assert property (s_pdLong |=> $stable(diffPairT[7:0]))
        else $error("main pairs run in power-down");
    AST_TEST_TRI: assert property (!seOe[0] |-> diffPairOe == 10'h000)
        else $error("pairs driven in test tri-state");
    AST_TEST_SE: assert property ($fell(seOe[0]) |-> seOe == 6'h00)
        else $error("outputs not tri together");
    AST_DIFF_CMP: assert property (diffPairOe[0] |-> diffPairC[0] != diffPairT[0])
        else $error("pair legs not complementary");
endmodule : clkc_props
bind clkc_output_ctrl clkc_props i_clkc_props (.*);

// [clkc_host.sv]
`timescale 1ns/10ps
// ====
// serial controller; released data line pulled up
module clkc_host (
    input wire logic mclk,
    input wire logic sdaOe,
    output logic sclLine,
    output logic sdaLine
);
    logic sdaD = 1'b1;
    initial sclLine = 1'b1;
    assign sdaLine = sdaD & !sdaOe;
    // quarter bit of 5 cycles keeps half periods at 10
    task automatic step(input logic c, input logic d);
        sclLine = c;
        sdaD = d;
        repeat (5) @(posedge mclk);
        #1;
    endtask : step
    task automatic start;
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start
    task automatic stop;
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop
    // data moves only while clock low
    task automatic bitx(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = sdaLine;
        step(1'b1, b);
        step(1'b0, b);
    endtask : bitx
    task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r[i]);
        bitx(m, a);
    endtask : xb
endmodule : clkc_host

// [clkc_output_ctrl_bench.sv]
`timescale 1ns/10ps
module clkc_output_ctrl_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic powerDownN = 1'b1;
    logic [1:0] clockRequestN = 2'b00;
    logic sclLine, sdaLine, sdaOut, sdaOe, k;
    logic [9:0] diffPairT, diffPairC, diffPairOe;
    logic [5:0] seClk, seOe;
    logic spreadOn, spreadDeep, usb48DriveSingle, bus33DriveSingle, link66LowDrive, refHighDrive;
    int errors = 0;
    int check_count = 0;
    int seed = 7554;
    int mdl [8];
    logic [7:0] v;
    clkc_output_ctrl i_clkc_output_ctrl (.*, .sclIn(sclLine), .sdaIn(sdaLine));
    clkc_host i_clkc_host (.*);
    initial forever #2 mclk = ~mclk;
    task automatic cmpReg(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %0t reg %h exp %h", $time, g, e);
        end
    endtask : cmpReg
    task automatic cmpPin(input logic [9:0] g, input logic [9:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %0t pins %h exp %h", $time, g, e);
        end
    endtask : cmpPin
    task automatic summarize;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : w
    function automatic logic [9:0] lvl;
        return {4'h0, mdl[2][2], mdl[2][7], mdl[2][6], mdl[2][5], mdl[3][0], mdl[6][5]};
    endfunction : lvl
    function automatic logic [7:0] expRd(input logic [7:0] c);
        if (c[6:5] != 2'b00 || c[4:0] > 5'h07)
            return 8'h00;
        return (c[4:0] == 5'h07) ? clkc_pkg::VENDOR_BYTE : 8'(mdl[c[4:0]]);
    endfunction : expRd
    task automatic addr(input logic rw, input logic [7:0] c);
        i_clkc_host.start;
        i_clkc_host.xb({clkc_pkg::SLAVE_ADDR, rw}, 1'b1, v, k);
        cmpPin({9'h000, k}, 10'h000);
        if (!rw)
            i_clkc_host.xb(c, 1'b1, v, k);
    endtask : addr
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        addr(1'b0, c);
        i_clkc_host.xb(d, 1'b1, v, k);
        i_clkc_host.stop;
        if (c[6:0] < 7'h07)
            mdl[c[4:0]] = d;
        cmpPin({spreadOn, spreadDeep, usb48DriveSingle, bus33DriveSingle, link66LowDrive,
            refHighDrive}, lvl());
    endtask : wr
    task automatic rd(input logic [7:0] c);
        addr(1'b0, c);
        addr(1'b1, c);
        i_clkc_host.xb(8'hFF, 1'b1, v, k);
        i_clkc_host.stop;
        cmpReg(v, expRd(c));
    endtask : rd
    task automatic blkRd;
        addr(1'b0, 8'h00);
        addr(1'b1, 8'h00);
        i_clkc_host.xb(8'hFF, 1'b0, v, k);
        cmpReg(v, clkc_pkg::BLOCK_LEN);
        for (int i = 0; i < 7; i++)
        begin
            i_clkc_host.xb(8'hFF, i == 6, v, k);
            cmpReg(v, 8'(mdl[i]));
        end
        i_clkc_host.stop;
    endtask : blkRd
    task automatic runCmp(input logic [9:0] e);
        for (int i = 0; i < 8; i++)
        begin
            w(1);
            cmpPin({diffPairT[5], diffPairT[0], seClk[5]}, e[2:0] | {{2{diffPairT[1]}}, 1'b0});
        end
    endtask : runCmp
    initial
    begin
        #400000;
        errors++;
        summarize;
    end
    initial
    begin
        mdl = '{8'hFF, 8'hFF, 8'hEB, 8'hAF, 8'h03, 8'h00, 8'h10, 8'h00};
        w(6);
        rst_n = 1'b1;
        w(4);
        blkRd;
        for (int i = 0; i < 9; i++)
        begin
            v = 8'($random(seed)) & ((i == 6) ? 8'h3F : 8'hFF);
            wr({3'b100, 5'(i)}, v);
            rd({3'b100, 5'(i)});
        end
        for (int i = 1; i < 4; i++)
        begin
            wr({1'b1, 2'(i), 5'h02}, 8'h5A);
            rd({1'b1, 2'(i), 5'h02});
        end
        i_clkc_host.start;
        i_clkc_host.xb(8'hA4, 1'b1, v, k);
        i_clkc_host.stop;
        cmpPin({9'h000, k}, 10'h001);
        addr(1'b0, 8'h00);
        i_clkc_host.xb(8'h03, 1'b1, v, k);
        for (int i = 0; i < 3; i++)
        begin
            mdl[i] = $random(seed) & 8'hFF;
            i_clkc_host.xb(8'(mdl[i]), 1'b1, v, k);
        end
        i_clkc_host.stop;
        blkRd;
        wr(8'h80, 8'hFF);
        wr(8'h81, 8'hFF);
        wr(8'h83, 8'h2F);
        wr(8'h84, 8'h07);
        wr(8'h85, 8'h80);
        wr(8'h86, 8'h00);
        clockRequestN = 2'b11;
        w(30);
        cmpPin({diffPairT[5], diffPairT[0], diffPairC[5], diffPairC[0], diffPairOe[1:0]},
            10'h033);
        wr(8'h83, 8'hAF);
        cmpPin(diffPairOe & 10'h023, 10'h002);
        clockRequestN = 2'b00;
        w(1);
        clockRequestN = 2'b01;
        w(1);
        clockRequestN = 2'b00;
        wr(8'h84, 8'h05);
        w(20);
        runCmp(10'h000);
        powerDownN = 1'b0;
        w(20);
        cmpPin(diffPairOe, 10'h300);
        cmpPin({8'h00, diffPairT[9:8]}, 10'h003);
        powerDownN = 1'b1;
        wr(8'h86, 8'h40);
        cmpPin({seOe, diffPairOe[3:0]}, 10'h000);
        wr(8'h86, 8'hC0);
        cmpPin({seOe, diffPairOe[3:0]}, 10'h3FF);
        for (int i = 0; i < 8; i++)
        begin
            w(3);
            cmpPin({diffPairT[9], diffPairT[0]}, {2{seClk[0]}});
        end
        wr(8'h86, 8'h10);
        summarize;
    end
endmodule : clkc_output_ctrl_bench
